// ==== dprc_pkg.sv ====
/*
  Constants for the dual-port RAM port controller: widths, mailbox addresses and the
  cycle counts that pace a write against arbitration.
  Assumes a 100 MHz clock and the RAM's wait flag sampled synchronously.
*/
package dprc_pkg;
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam logic [10:0] MAIL_TO_RIGHT_ADDR = 11'h07FF;
  localparam logic [10:0] MAIL_TO_LEFT_ADDR = 11'h07FE;
  localparam int CLK_PERIOD_NS = 10;
  localparam int ARB_TIME_NS = 45;
  localparam int WRITE_HOLD_NS = 20;
  localparam int WRITE_PULSE_NS = 40;
  localparam logic [3:0] ARB_CYC = 4'((ARB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] HOLD_CYC = 4'((WRITE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] PULSE_CYC = 4'((WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] READ_CYC = 4'h4;
  localparam logic [3:0] WAIT_LIMIT = 4'hF;
  typedef enum logic [2:0] {
    DPRC_IDLE, DPRC_SELECT, DPRC_READ, DPRC_WSETTLE, DPRC_WPULSE, DPRC_WHOLD, DPRC_DONE
  } dprc_state_type;
endpackage

// ==== dprc_port_ctrl.sv ====
/*
  One-port controller that drives a dual-port RAM port through its pins.
  Assumes the wait flag input is synchronous to CLK and that the RAM pins are driven
  straight from these outputs.
*/
`timescale 1ns/10ps
// Notes on behaviour
// - Delay slave write until wait settles.
// - Keep write strobe active past wait.
// - Delay strobe by worst arbitration time.
// - Write strobe high throughout read cycles.
module dprc_port_ctrl
  import dprc_pkg::*;
(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire logic REQ_WRITE,
  input wire logic [ADDR_W-1:0] REQ_ADDR,
  input wire logic [DATA_W-1:0] REQ_WDATA,
  output logic RSP_VALID,
  output logic [DATA_W-1:0] RSP_RDATA,
  output logic RSP_RETRY,
  output logic CHIP_SELECT_N,
  output logic WRITE_STROBE_N,
  output logic OUTPUT_GATE_N,
  output logic [ADDR_W-1:0] ADDR,
  output logic [DATA_W-1:0] DATA_OUT,
  output logic DATA_OE_N,
  input wire logic [DATA_W-1:0] DATA_IN,
  input wire logic WAIT_FLAG_N
);
  // ==========================================================================
  // State and pacing.
  dprc_state_type state_q;
  logic [3:0] cnt_q;
  logic write_q;
  logic abandon_q;
  logic [3:0] sel_age_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;

  assign REQ_READY = (state_q == DPRC_IDLE);

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      state_q <= DPRC_IDLE;
      cnt_q <= 4'h0;
      abandon_q <= 1'b0;
    end else begin
      unique case (state_q)
        DPRC_IDLE: begin
          cnt_q <= 4'h0;
          abandon_q <= 1'b0;
          if (REQ_VALID) begin
            state_q <= DPRC_SELECT;
          end
        end
        DPRC_SELECT: begin
          // Address and select settle one cycle before the gate moves and at least seven cycles before the strobe.
          cnt_q <= 4'h0;
          state_q <= write_q ? DPRC_WSETTLE : DPRC_READ;
        end
        DPRC_READ: begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q >= READ_CYC) begin
            state_q <= DPRC_DONE;
          end
        end
        DPRC_WSETTLE: begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q >= ARB_CYC && WAIT_FLAG_N) begin
            state_q <= DPRC_WPULSE;
            cnt_q <= 4'h0;
          end else if (cnt_q == WAIT_LIMIT) begin
            // The wait flag never cleared, so give up without a strobe and report a retry.
            abandon_q <= 1'b1;
            cnt_q <= 4'h0;
            state_q <= DPRC_DONE;
          end
        end
        DPRC_WPULSE: begin
          if (!WAIT_FLAG_N) begin
            cnt_q <= 4'h0;
          end else begin
            cnt_q <= cnt_q + 4'h1;
          end
          if (WAIT_FLAG_N && cnt_q >= PULSE_CYC + HOLD_CYC) begin
            state_q <= DPRC_WHOLD;
          end
        end
        DPRC_WHOLD: begin
          // Strobe has risen; select drops two cycles later, never together.
          state_q <= DPRC_DONE;
        end
        DPRC_DONE: begin
          state_q <= DPRC_IDLE;
        end
        default: begin
          state_q <= DPRC_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Request capture.
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      write_q <= 1'b0;
      addr_q <= '0;
      wdata_q <= '0;
    end else if (state_q == DPRC_IDLE && REQ_VALID) begin
      write_q <= REQ_WRITE;
      addr_q <= REQ_ADDR;
      wdata_q <= REQ_WDATA;
    end
  end

  // ==========================================================================
  // Pin drive.
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      CHIP_SELECT_N <= 1'b1;
      WRITE_STROBE_N <= 1'b1;
      OUTPUT_GATE_N <= 1'b1;
      DATA_OE_N <= 1'b1;
      ADDR <= '0;
      DATA_OUT <= '0;
    end else begin
      ADDR <= addr_q;
      DATA_OUT <= wdata_q;
      CHIP_SELECT_N <= !(state_q inside {DPRC_SELECT, DPRC_READ, DPRC_WSETTLE,
                                        DPRC_WPULSE, DPRC_WHOLD});
      WRITE_STROBE_N <= !(state_q == DPRC_WPULSE && !(WAIT_FLAG_N
                        && cnt_q >= PULSE_CYC + HOLD_CYC));
      OUTPUT_GATE_N <= !(state_q == DPRC_READ && cnt_q < READ_CYC);
      DATA_OE_N <= !(state_q inside {DPRC_WSETTLE, DPRC_WPULSE});
    end
  end

  // ==========================================================================
  // Answers.
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      RSP_VALID <= 1'b0;
      RSP_RDATA <= '0;
      RSP_RETRY <= 1'b0;
    end else begin
      RSP_VALID <= (state_q == DPRC_DONE);
      RSP_RETRY <= (state_q == DPRC_DONE) && abandon_q;
      if (state_q == DPRC_READ && cnt_q == READ_CYC) begin
        RSP_RDATA <= DATA_IN;
      end
    end
  end

  // ==========================================================================
  // Checks.
  // Counts the cycles for which the select has been low, saturating at the top.
  always_ff @(posedge CLK) begin
    if (!NRST || CHIP_SELECT_N) begin
      sel_age_q <= 4'h0;
    end else if (sel_age_q != 4'hF) begin
      sel_age_q <= sel_age_q + 4'h1;
    end
  end

  sequence s_strobe_low;
    !WRITE_STROBE_N;
  endsequence

  a_read_strobe_high: assert property (@(posedge CLK) disable iff (!NRST)
    !OUTPUT_GATE_N |-> WRITE_STROBE_N)
    else $error("Strobe low during read.");
  a_no_joint_rise: assert property (@(posedge CLK) disable iff (!NRST)
    ($rose(WRITE_STROBE_N) |-> !CHIP_SELECT_N))
    else $error("Select rose with strobe.");
  a_strobe_after_arb: assert property (@(posedge CLK) disable iff (!NRST)
    $fell(WRITE_STROBE_N) |-> sel_age_q > ARB_CYC && $past(state_q) == DPRC_WPULSE)
    else $error("Strobe fell before arbitration time.");
  a_standby_idle: assert property (@(posedge CLK) disable iff (!NRST)
    CHIP_SELECT_N |-> WRITE_STROBE_N && OUTPUT_GATE_N && DATA_OE_N)
    else $error("Pins active in standby.");
  a_select_first: assert property (@(posedge CLK) disable iff (!NRST)
    $fell(CHIP_SELECT_N) |=> WRITE_STROBE_N)
    else $error("Strobe with select.");
  a_gate_no_drive: assert property (@(posedge CLK) disable iff (!NRST)
    !OUTPUT_GATE_N |-> DATA_OE_N)
    else $error("Both sides driving data.");
  a_strobe_hold: assert property (@(posedge CLK) disable iff (!NRST)
    $fell(WRITE_STROBE_N) |-> s_strobe_low [*6])
    else $error("Strobe pulse too short.");
  a_answer_once: assert property (@(posedge CLK) disable iff (!NRST)
    RSP_VALID |=> !RSP_VALID)
    else $error("Answer held.");
  a_wait_settled: assert property (@(posedge CLK) disable iff (!NRST)
    $fell(WRITE_STROBE_N) |-> $past(WAIT_FLAG_N, 2))
    else $error("Strobe fell while wait was low.");
  a_hold_past_wait: assert property (@(posedge CLK) disable iff (!NRST)
    $rose(WRITE_STROBE_N) |-> $past(WAIT_FLAG_N) && $past(WAIT_FLAG_N, 2))
    else $error("Strobe rose without hold past wait.");
  a_data_under_strobe: assert property (@(posedge CLK) disable iff (!NRST)
    !WRITE_STROBE_N |-> !DATA_OE_N && !CHIP_SELECT_N)
    else $error("Strobe low without data or select.");
  a_gate_under_select: assert property (@(posedge CLK) disable iff (!NRST)
    !OUTPUT_GATE_N |-> !CHIP_SELECT_N)
    else $error("Gate low without select.");
endmodule

// ==== dprc_ram_model.sv ====
/* Behavioural model of one port of the dual-port RAM.
   Assumes the bench resolves the shared data bus and drives the contention input. */
`timescale 1ns/10ps
// ==========
// Port model
module dprc_ram_model
  import dprc_pkg::*;
(
  input wire logic cs_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] din,
  input wire logic contend_n,
  output logic wait_n,
  output logic q_en,
  output logic [DATA_W-1:0] q,
  output logic peer_mail_n,
  output logic peer_any_n
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] wd;
  logic mail_q = 1'b1;
  logic any_q = 1'b1;
  assign peer_mail_n = mail_q;
  assign peer_any_n = any_q;
  assign wait_n = cs_n | contend_n;
  assign q_en = !cs_n && we_n && !oe_n;
  assign q = mem[addr];
  always @(din or we_n) begin
    if (!we_n) begin
      wd = din;
    end
  end
  always @(posedge we_n) begin
    if (!cs_n && (wait_n || !oe_n)) begin
      mem[addr] <= wd;
    end
    if (!cs_n && wait_n) begin
      any_q <= 1'b0;
      if (addr == MAIL_TO_RIGHT_ADDR) begin
        mail_q <= 1'b0;
      end
    end
  end
endmodule

// ==== tb_dprc_port_ctrl.sv ====
/* Self-checking bench for the port controller against a RAM port model.
   Assumes the package constants and a 100 MHz clock. */
`timescale 1ns/10ps
module tb_dprc_port_ctrl
  import dprc_pkg::*;
;
  logic clk = 0, nrst = 0, req_valid = 0, req_write = 0, contend_n = 1;
  logic [ADDR_W-1:0] req_addr = '0, addr;
  logic [DATA_W-1:0] req_wdata = '0, bus_last = '0, rsp_rdata, dout, q, data_in;
  logic [DATA_W-1:0] ref_mem [0:2047];
  logic req_ready, rsp_valid, rsp_retry, cs_n, we_n, oe_n, doe_n, wait_n, q_en;
  logic peer_mail_n, peer_any_n;
  int miscompares = 0, checks = 0;
  dprc_port_ctrl i_dut (.CLK(clk), .NRST(nrst), .REQ_VALID(req_valid), .REQ_READY(req_ready),
    .REQ_WRITE(req_write), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata), .RSP_VALID(rsp_valid),
    .RSP_RDATA(rsp_rdata), .RSP_RETRY(rsp_retry), .CHIP_SELECT_N(cs_n), .WRITE_STROBE_N(we_n),
    .OUTPUT_GATE_N(oe_n), .ADDR(addr), .DATA_OUT(dout), .DATA_OE_N(doe_n), .DATA_IN(data_in),
    .WAIT_FLAG_N(wait_n));
  dprc_ram_model i_ram (.cs_n(cs_n), .we_n(we_n), .oe_n(oe_n), .addr(addr), .din(data_in),
    .contend_n(contend_n), .wait_n(wait_n), .q_en(q_en), .q(q), .peer_mail_n(peer_mail_n),
    .peer_any_n(peer_any_n));
  assign data_in = !doe_n ? dout : (q_en ? q : ~bus_last);
  always @(posedge clk) bus_last <= data_in;
  initial forever #5 clk = ~clk;
  // ==========
  // Tasks
  function automatic logic [7:0] exp_rd(input logic [10:0] a);
    return ref_mem[a];
  endfunction
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_bit(input string n, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic req(input logic w, input logic [10:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    req_valid <= 1'b1;
    @(negedge clk);
    while (req_ready !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    req_valid <= 1'b0;
    do begin
      @(negedge clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 200);
    chk_bit("answer", 1'b1, rsp_valid);
  endtask
  task automatic close_out();
    if (miscompares == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ==========
  // Tests
  initial begin
    logic [10:0] a;
    logic [7:0] d;
    void'($urandom(76));
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    chk_bit("any flag idle", 1'b1, peer_any_n);
    for (int i = 0; i < 24; i++) begin
      a = i == 0 ? MAIL_TO_LEFT_ADDR : i == 1 ? MAIL_TO_RIGHT_ADDR : i == 2 ? '0 : 11'($urandom);
      d = 8'($urandom);
      req(1'b1, a, d);
      chk_bit("retry", 1'b0, rsp_retry);
      if (i == 0) begin
        chk_bit("mail flag early", 1'b1, peer_mail_n);
        chk_bit("any flag", 1'b0, peer_any_n);
      end
      ref_mem[a] = d;
      req(1'b0, a, 8'h00);
      chk("read", exp_rd(a), rsp_rdata);
    end
    chk_bit("mail flag", 1'b0, peer_mail_n);
    @(posedge clk);
    contend_n <= 1'b0;
    fork
      req(1'b1, 11'h123, 8'h5a);
      begin
        repeat (6) @(posedge clk);
        contend_n <= 1'b1;
      end
    join
    chk_bit("stall retry", 1'b0, rsp_retry);
    ref_mem[11'h123] = 8'h5a;
    req(1'b0, 11'h123, 8'h00);
    chk("stall read", exp_rd(11'h123), rsp_rdata);
    fork
      req(1'b1, 11'h124, 8'h3c);
      begin
        repeat (12) @(posedge clk);
        contend_n <= 1'b0;
        repeat (3) @(posedge clk);
        contend_n <= 1'b1;
      end
    join
    chk_bit("pulse stall retry", 1'b0, rsp_retry);
    ref_mem[11'h124] = 8'h3c;
    req(1'b0, 11'h124, 8'h00);
    chk("pulse stall read", exp_rd(11'h124), rsp_rdata);
    @(posedge clk);
    contend_n <= 1'b0;
    req(1'b1, 11'h123, 8'ha5);
    chk_bit("abandon", 1'b1, rsp_retry);
    @(posedge clk);
    contend_n <= 1'b1;
    req(1'b0, 11'h123, 8'h00);
    chk("kept", exp_rd(11'h123), rsp_rdata);
    @(posedge clk);
    req_write <= 1'b1;
    req_addr <= 11'h123;
    req_wdata <= 8'h77;
    req_valid <= 1'b1;
    @(posedge clk);
    req_valid <= 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk_bit("reset select", 1'b1, cs_n);
    req(1'b0, 11'h123, 8'h00);
    chk("reset kept", exp_rd(11'h123), rsp_rdata);
    close_out();
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    close_out();
  end
endmodule
